// File: core/ppc_pkg.sv
// constants, field positions and mode types of the parallel port control block
// Function
// - control word with bit 7 low is a single-bit Port C set/reset command
// - set/reset forces any one of eight Port C bits, others unchanged
// - command bits three to one pick the bit, bit zero gives its level
// - word 10010101 gives A basic input, B strobed output, C upper out, lower in
// - reading a port set as output returns its latched value
// - Port C read in strobed mode returns handshake status word
// - interrupt enables are internal flops seen only through Port C reads
// - status word layout follows the modes and directions of ports A and B
// - buffer-full bits ignore Port C writes and set/reset commands; request bits follow the enables they change
// - direct Port C write may change enables; host uses set/reset for free bits
// - bidirectional status: out full, out enable, in full, in enable, request A
// - bidirectional status bits two to zero follow the port B setup
// - bidirectional enables sit at bits six and four, writable by set/reset
// - commands 0d/0c and 09/08 enable/disable output and input interrupts
// - control word with bit 7 high sets modes and directions of all groups
// - two select lines pick A, B, C or command register, qualified by select
// - basic mode outputs stay latched, input reads return live pins
package ppc_pkg;
	localparam logic [1:0] SEL_PORT_A = 2'h0;
	localparam logic [1:0] SEL_PORT_B = 2'h1;
	localparam logic [1:0] SEL_PORT_C = 2'h2;
	localparam logic [1:0] SEL_CMD    = 2'h3;

	// command word fields
	localparam int CW_OPCODE  = 7;
	localparam int CW_IDX_HI  = 3;
	localparam int CW_IDX_LO  = 1;
	localparam int CW_LEVEL   = 0;
	localparam int MW_GA_HI   = 6;
	localparam int MW_GA_LO   = 5;
	localparam int MW_PA_IN   = 4;
	localparam int MW_PCU_IN  = 3;
	localparam int MW_GB_MODE = 2;
	localparam int MW_PB_IN   = 1;
	localparam int MW_PCL_IN  = 0;

	localparam logic [7:0] RESET_MODE_WORD   = 8'h9b;
	localparam logic [7:0] EXAMPLE_MODE_WORD = 8'h95;
	localparam logic [7:0] BYTE_ZERO         = 8'h00;
	localparam logic [3:0] NIB_ZERO          = 4'h0;

	// Port C positions used by the handshake groups
	localparam logic [2:0] PC_INTR_B = 3'h0;
	localparam logic [2:0] PC_BF_B   = 3'h1;
	localparam logic [2:0] PC_HS_B   = 3'h2;
	localparam logic [2:0] PC_INTR_A = 3'h3;
	localparam logic [2:0] PC_STB_A  = 3'h4;
	localparam logic [2:0] PC_IBF_A  = 3'h5;
	localparam logic [2:0] PC_ACK_A  = 3'h6;
	localparam logic [2:0] PC_OBF_A  = 3'h7;

	typedef enum logic [2:0] {
		GA_BASIC    = 3'b001,
		GA_STROBED  = 3'b010,
		GA_BIDIR    = 3'b100
	} ppc_gmode_t;
endpackage

// File: core/ppc_port_ctrl.sv
// control word decoder, port latches and Port C handshake/status logic
`timescale 1ns/1ns
module ppc_port_ctrl (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_cs,
	input  wire logic       i_port_sel_hi,
	input  wire logic       i_port_sel_lo,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic [7:0] i_wdata,
	output logic [7:0]      o_rdata,
	output logic            o_rd_valid,
	input  wire logic [7:0] i_pa,
	output logic [7:0]      o_pa,
	output logic            o_pa_oe_n,
	input  wire logic [7:0] i_pb,
	output logic [7:0]      o_pb,
	output logic            o_pb_oe_n,
	input  wire logic [7:0] i_pc,
	output logic [7:0]      o_pc,
	output logic [7:0]      o_pc_oe_n
);
	//--------------------------------------------------
	// access decode
	//--------------------------------------------------
	logic [1:0]          sel;
	logic                wr_acc;
	logic                rd_acc;
	logic                wr_cmd;
	logic                is_mode;
	logic                is_bsr;
	logic                wr_pc;
	logic [2:0]          bsr_idx;
	logic                bsr_lvl;
	ppc_pkg::ppc_gmode_t ga_mode;
	ppc_pkg::ppc_gmode_t next_ga_mode;
	logic                pa_in;
	logic                pb_in;
	logic                pcu_in;
	logic                pcl_in;
	logic                gb_strobed;
	logic [7:0]          pa_latch;
	logic [7:0]          pb_latch;
	logic [7:0]          pc_latch;
	logic [7:0]          pa_in_latch;
	logic [7:0]          pb_in_latch;
	logic                in_buf_full_grp_a;
	logic                out_buf_full_grp_a;
	logic                in_buf_full_grp_b;
	logic                out_buf_full_grp_b;
	logic                irq_req_grp_a;
	logic                irq_req_grp_b;
	logic                irq_en_grp_a;
	logic                irq_en_grp_b;
	logic                out_irq_en_bidir;
	logic                in_irq_en_bidir;
	logic [2:0]          ga_en_pos;
	logic                a_takes_in;
	logic                a_gives_out;
	logic                stb_a_n;
	logic                ack_a_n;
	logic                hs_b_n;
	logic [7:0]          status_word;
	logic [7:0]          next_pc;
	logic [7:0]          next_pc_drv;

	assign sel     = {i_port_sel_hi, i_port_sel_lo};
	assign wr_acc  = i_cs & i_wr;
	assign rd_acc  = i_cs & i_rd;
	assign wr_cmd  = wr_acc & (sel == ppc_pkg::SEL_CMD);
	assign is_mode = wr_cmd & i_wdata[ppc_pkg::CW_OPCODE];
	assign is_bsr  = wr_cmd & ~i_wdata[ppc_pkg::CW_OPCODE];
	assign wr_pc   = wr_acc & (sel == ppc_pkg::SEL_PORT_C);
	// bits six to four of a set/reset command are never looked at
	assign bsr_idx = i_wdata[ppc_pkg::CW_IDX_HI:ppc_pkg::CW_IDX_LO];
	assign bsr_lvl = i_wdata[ppc_pkg::CW_LEVEL];

	assign stb_a_n     = i_pc[ppc_pkg::PC_STB_A];
	assign ack_a_n     = i_pc[ppc_pkg::PC_ACK_A];
	assign hs_b_n      = i_pc[ppc_pkg::PC_HS_B];
	assign a_takes_in  = (ga_mode == ppc_pkg::GA_BIDIR) | ((ga_mode == ppc_pkg::GA_STROBED) & pa_in);
	assign a_gives_out = (ga_mode == ppc_pkg::GA_BIDIR) | ((ga_mode == ppc_pkg::GA_STROBED) & ~pa_in);
	assign ga_en_pos   = pa_in ? ppc_pkg::PC_STB_A : ppc_pkg::PC_ACK_A;

	always_comb
	begin
		case (i_wdata[ppc_pkg::MW_GA_HI:ppc_pkg::MW_GA_LO])
			2'h0:    next_ga_mode = ppc_pkg::GA_BASIC;
			2'h1:    next_ga_mode = ppc_pkg::GA_STROBED;
			default: next_ga_mode = ppc_pkg::GA_BIDIR;
		endcase
	end

	//--------------------------------------------------
	// mode register
	//--------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			ga_mode    <= ppc_pkg::GA_BASIC;
			pa_in      <= 1'b1;
			pcu_in     <= 1'b1;
			gb_strobed <= 1'b0;
			pb_in      <= 1'b1;
			pcl_in     <= 1'b1;
		end
		else if (is_mode)
		begin
			ga_mode    <= next_ga_mode;
			pa_in      <= i_wdata[ppc_pkg::MW_PA_IN];
			pcu_in     <= i_wdata[ppc_pkg::MW_PCU_IN];
			gb_strobed <= i_wdata[ppc_pkg::MW_GB_MODE];
			pb_in      <= i_wdata[ppc_pkg::MW_PB_IN];
			pcl_in     <= i_wdata[ppc_pkg::MW_PCL_IN];
		end
	end

	//--------------------------------------------------
	// output latches; a new mode word clears them
	//--------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst || is_mode)
		begin
			pa_latch <= ppc_pkg::BYTE_ZERO;
			pb_latch <= ppc_pkg::BYTE_ZERO;
			pc_latch <= ppc_pkg::BYTE_ZERO;
		end
		else
		begin
			if (wr_acc && sel == ppc_pkg::SEL_PORT_A)
				pa_latch <= i_wdata;
			if (wr_acc && sel == ppc_pkg::SEL_PORT_B)
				pb_latch <= i_wdata;
			if (wr_pc)
				pc_latch <= i_wdata;
			else if (is_bsr)
				pc_latch[bsr_idx] <= bsr_lvl;
		end
	end

	//--------------------------------------------------
	// interrupt enable flops, reachable only through Port C
	//--------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst || is_mode)
		begin
			irq_en_grp_a     <= 1'b0;
			irq_en_grp_b     <= 1'b0;
			out_irq_en_bidir <= 1'b0;
			in_irq_en_bidir  <= 1'b0;
		end
		else if (is_bsr)
		begin
			if (bsr_idx == ga_en_pos)
				irq_en_grp_a <= bsr_lvl;
			if (bsr_idx == ppc_pkg::PC_HS_B)
				irq_en_grp_b <= bsr_lvl;
			if (bsr_idx == ppc_pkg::PC_ACK_A)
				out_irq_en_bidir <= bsr_lvl;
			if (bsr_idx == ppc_pkg::PC_STB_A)
				in_irq_en_bidir <= bsr_lvl;
		end
		else if (wr_pc)
		begin
			// a whole-port write lands on the enables too
			irq_en_grp_a     <= i_wdata[ga_en_pos];
			irq_en_grp_b     <= i_wdata[ppc_pkg::PC_HS_B];
			out_irq_en_bidir <= i_wdata[ppc_pkg::PC_ACK_A];
			in_irq_en_bidir  <= i_wdata[ppc_pkg::PC_STB_A];
		end
	end

	//--------------------------------------------------
	// handshake flags; Port C writes reach only the request flags, through the enables
	//--------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst || is_mode)
		begin
			in_buf_full_grp_a  <= 1'b0;
			out_buf_full_grp_a <= 1'b0;
			in_buf_full_grp_b  <= 1'b0;
			out_buf_full_grp_b <= 1'b0;
			irq_req_grp_a      <= 1'b0;
			irq_req_grp_b      <= 1'b0;
			pa_in_latch        <= ppc_pkg::BYTE_ZERO;
			pb_in_latch        <= ppc_pkg::BYTE_ZERO;
		end
		else
		begin
			// strobe set wins over a read clear in the same cycle
			if (a_takes_in && !stb_a_n)
			begin
				in_buf_full_grp_a <= 1'b1;
				pa_in_latch       <= i_pa;
			end
			else if (rd_acc && sel == ppc_pkg::SEL_PORT_A)
				in_buf_full_grp_a <= 1'b0;
			if (a_gives_out && wr_acc && sel == ppc_pkg::SEL_PORT_A)
				out_buf_full_grp_a <= 1'b1;
			else if (!ack_a_n)
				out_buf_full_grp_a <= 1'b0;
			if (gb_strobed && pb_in && !hs_b_n)
			begin
				in_buf_full_grp_b <= 1'b1;
				pb_in_latch       <= i_pb;
			end
			else if (rd_acc && sel == ppc_pkg::SEL_PORT_B)
				in_buf_full_grp_b <= 1'b0;
			if (gb_strobed && !pb_in && wr_acc && sel == ppc_pkg::SEL_PORT_B)
				out_buf_full_grp_b <= 1'b1;
			else if (!hs_b_n)
				out_buf_full_grp_b <= 1'b0;
			case (ga_mode)
				ppc_pkg::GA_STROBED:
					irq_req_grp_a <= irq_en_grp_a & (pa_in ? (in_buf_full_grp_a & stb_a_n)
						: (~out_buf_full_grp_a & ack_a_n));
				ppc_pkg::GA_BIDIR:
					irq_req_grp_a <= (in_irq_en_bidir & in_buf_full_grp_a & stb_a_n)
						| (out_irq_en_bidir & ~out_buf_full_grp_a & ack_a_n);
				default:
					irq_req_grp_a <= 1'b0;
			endcase
			irq_req_grp_b <= gb_strobed & irq_en_grp_b & hs_b_n
				& (pb_in ? in_buf_full_grp_b : ~out_buf_full_grp_b);
		end
	end

	ppc_status_word u_status (
		.i_ga_mode      (ga_mode),
		.i_pa_in        (pa_in),
		.i_gb_strobed   (gb_strobed),
		.i_pb_in        (pb_in),
		.i_pcu_in       (pcu_in),
		.i_pcl_in       (pcl_in),
		.i_pc_latch     (pc_latch),
		.i_pc_pins      (i_pc),
		.i_ibf_a        (in_buf_full_grp_a),
		.i_obf_a        (out_buf_full_grp_a),
		.i_irq_a        (irq_req_grp_a),
		.i_ibf_b        (in_buf_full_grp_b),
		.i_obf_b        (out_buf_full_grp_b),
		.i_irq_b        (irq_req_grp_b),
		.i_en_a         (irq_en_grp_a),
		.i_en_b         (irq_en_grp_b),
		.i_en_out_bidir (out_irq_en_bidir),
		.i_en_in_bidir  (in_irq_en_bidir),
		.o_word         (status_word)
	);

	//--------------------------------------------------
	// read data
	//--------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_rdata    <= ppc_pkg::BYTE_ZERO;
			o_rd_valid <= 1'b0;
		end
		else
		begin
			o_rd_valid <= rd_acc;
			if (rd_acc)
			begin
				case (sel)
					ppc_pkg::SEL_PORT_A:
						o_rdata <= a_takes_in ? pa_in_latch : (pa_in ? i_pa : pa_latch);
					ppc_pkg::SEL_PORT_B:
						o_rdata <= (gb_strobed && pb_in) ? pb_in_latch : (pb_in ? i_pb : pb_latch);
					ppc_pkg::SEL_PORT_C:
						o_rdata <= status_word;
					default:
						o_rdata <= ppc_pkg::BYTE_ZERO;
				endcase
			end
		end
	end

	//--------------------------------------------------
	// pin drivers
	//--------------------------------------------------
	always_comb
	begin
		next_pc     = pc_latch;
		next_pc_drv = {{4{~pcu_in}}, {4{~pcl_in}}};
		if (ga_mode != ppc_pkg::GA_BASIC)
		begin
			next_pc[ppc_pkg::PC_INTR_A]     = irq_req_grp_a;
			next_pc[ppc_pkg::PC_IBF_A]      = in_buf_full_grp_a;
			next_pc[ppc_pkg::PC_OBF_A]      = ~out_buf_full_grp_a;
			next_pc_drv[ppc_pkg::PC_INTR_A] = 1'b1;
			next_pc_drv[ppc_pkg::PC_IBF_A]  = a_takes_in | (pcu_in ? 1'b0 : 1'b1);
			next_pc_drv[ppc_pkg::PC_OBF_A]  = a_gives_out | (pcu_in ? 1'b0 : 1'b1);
			if (a_takes_in)
				next_pc_drv[ppc_pkg::PC_STB_A] = 1'b0;
			else
				next_pc[ppc_pkg::PC_IBF_A] = pc_latch[ppc_pkg::PC_IBF_A];
			if (a_gives_out)
				next_pc_drv[ppc_pkg::PC_ACK_A] = 1'b0;
			else
				next_pc[ppc_pkg::PC_OBF_A] = pc_latch[ppc_pkg::PC_OBF_A];
		end
		if (gb_strobed)
		begin
			next_pc[ppc_pkg::PC_INTR_B]     = irq_req_grp_b;
			next_pc[ppc_pkg::PC_BF_B]       = pb_in ? in_buf_full_grp_b : ~out_buf_full_grp_b;
			next_pc_drv[ppc_pkg::PC_INTR_B] = 1'b1;
			next_pc_drv[ppc_pkg::PC_BF_B]   = 1'b1;
			next_pc_drv[ppc_pkg::PC_HS_B]   = 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_pc_pin
			always_ff @(posedge i_clk)
			begin
				if (i_rst)
				begin
					o_pc[gi]      <= 1'b0;
					o_pc_oe_n[gi] <= 1'b1;
				end
				else
				begin
					o_pc[gi]      <= next_pc[gi];
					o_pc_oe_n[gi] <= ~next_pc_drv[gi];
				end
			end
		end
	endgenerate

	// bidirectional port A only drives while the peripheral acknowledges
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_pa      <= ppc_pkg::BYTE_ZERO;
			o_pa_oe_n <= 1'b1;
			o_pb      <= ppc_pkg::BYTE_ZERO;
			o_pb_oe_n <= 1'b1;
		end
		else
		begin
			o_pa      <= pa_latch;
			o_pa_oe_n <= (ga_mode == ppc_pkg::GA_BIDIR) ? ack_a_n : pa_in;
			o_pb      <= pb_latch;
			o_pb_oe_n <= pb_in;
		end
	end

	//--------------------------------------------------
	// checks
	//--------------------------------------------------
	logic [7:0] bsr_mask_q;
	always_ff @(posedge i_clk)
		bsr_mask_q <= {7'h00, 1'b1} << bsr_idx;

	bsr_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
		is_bsr |=> ((pc_latch & bsr_mask_q) != 8'h00) == $past(bsr_lvl))
		else $error("set/reset level not applied");
	bsr_others_a: assert property (@(posedge i_clk) disable iff (i_rst)
		is_bsr |=> (pc_latch & ~bsr_mask_q) == ($past(pc_latch) & ~bsr_mask_q))
		else $error("set/reset touched other bits");
	mode_example_a: assert property (@(posedge i_clk) disable iff (i_rst)
		is_mode && i_wdata == ppc_pkg::EXAMPLE_MODE_WORD |=> ga_mode == ppc_pkg::GA_BASIC
		&& pa_in && gb_strobed && !pb_in && !pcu_in && pcl_in)
		else $error("example mode word decoded wrongly");
	out_readback_a: assert property (@(posedge i_clk) disable iff (i_rst)
		rd_acc && sel == ppc_pkg::SEL_PORT_A && ga_mode == ppc_pkg::GA_BASIC && !pa_in
		|=> o_rd_valid && o_rdata == $past(pa_latch))
		else $error("output port readback wrong");
	in_live_a: assert property (@(posedge i_clk) disable iff (i_rst)
		rd_acc && sel == ppc_pkg::SEL_PORT_B && !gb_strobed && pb_in
		|=> o_rdata == $past(i_pb))
		else $error("basic input read not live");
	flags_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_pc || is_bsr) && stb_a_n && ack_a_n |=> $stable(in_buf_full_grp_a)
		&& $stable(out_buf_full_grp_a))
		else $error("status flag moved on port C write");
	bidir_status_a: assert property (@(posedge i_clk) disable iff (i_rst)
		rd_acc && sel == ppc_pkg::SEL_PORT_C && ga_mode == ppc_pkg::GA_BIDIR
		|=> o_rdata[7:3] == $past({out_buf_full_grp_a, out_irq_en_bidir,
		in_buf_full_grp_a, in_irq_en_bidir, irq_req_grp_a}))
		else $error("bidirectional status word wrong");
	bidir_enable_a: assert property (@(posedge i_clk) disable iff (i_rst)
		is_bsr && bsr_idx == ppc_pkg::PC_ACK_A ##1 ga_mode == ppc_pkg::GA_BIDIR
		|-> out_irq_en_bidir == $past(bsr_lvl))
		else $error("output interrupt enable not written");
	reset_state_a: assert property (@(posedge i_clk)
		i_rst |=> pa_in && pb_in && pcu_in && pcl_in && !irq_en_grp_a && !irq_en_grp_b
		&& !out_irq_en_bidir && !in_irq_en_bidir)
		else $error("reset state wrong");

	mode_write_c: cover property (@(posedge i_clk) disable iff (i_rst) is_mode);
	bidir_read_c: cover property (@(posedge i_clk) disable iff (i_rst)
		ga_mode == ppc_pkg::GA_BIDIR && rd_acc && sel == ppc_pkg::SEL_PORT_C);
	irq_a_c: cover property (@(posedge i_clk) disable iff (i_rst) irq_req_grp_a);
	strobe_fill_c: cover property (@(posedge i_clk) disable iff (i_rst)
		in_buf_full_grp_b ##1 rd_acc && sel == ppc_pkg::SEL_PORT_B);
endmodule

// File: core/ppc_status_word.sv
// builds the Port C read value from pins, latch and handshake flags
`timescale 1ns/1ns
module ppc_status_word (
	input  wire ppc_pkg::ppc_gmode_t i_ga_mode,
	input  wire logic                i_pa_in,
	input  wire logic                i_gb_strobed,
	input  wire logic                i_pb_in,
	input  wire logic                i_pcu_in,
	input  wire logic                i_pcl_in,
	input  wire logic [7:0]          i_pc_latch,
	input  wire logic [7:0]          i_pc_pins,
	input  wire logic                i_ibf_a,
	input  wire logic                i_obf_a,
	input  wire logic                i_irq_a,
	input  wire logic                i_ibf_b,
	input  wire logic                i_obf_b,
	input  wire logic                i_irq_b,
	input  wire logic                i_en_a,
	input  wire logic                i_en_b,
	input  wire logic                i_en_out_bidir,
	input  wire logic                i_en_in_bidir,
	output logic [7:0]               o_word
);
	always_comb
	begin
		// free bits: output bits read back the latch, input bits the live pins
		o_word[7:4] = i_pcu_in ? i_pc_pins[7:4] : i_pc_latch[7:4];
		o_word[3:0] = i_pcl_in ? i_pc_pins[3:0] : i_pc_latch[3:0];
		case (i_ga_mode)
			ppc_pkg::GA_STROBED:
			begin
				o_word[ppc_pkg::PC_INTR_A] = i_irq_a;
				if (i_pa_in)
				begin
					o_word[ppc_pkg::PC_STB_A] = i_en_a;
					o_word[ppc_pkg::PC_IBF_A] = i_ibf_a;
				end
				else
				begin
					o_word[ppc_pkg::PC_ACK_A] = i_en_a;
					o_word[ppc_pkg::PC_OBF_A] = i_obf_a;
				end
			end
			ppc_pkg::GA_BIDIR:
			begin
				o_word[ppc_pkg::PC_OBF_A]  = i_obf_a;
				o_word[ppc_pkg::PC_ACK_A]  = i_en_out_bidir;
				o_word[ppc_pkg::PC_IBF_A]  = i_ibf_a;
				o_word[ppc_pkg::PC_STB_A]  = i_en_in_bidir;
				o_word[ppc_pkg::PC_INTR_A] = i_irq_a;
			end
			default:
			begin
				// basic mode: upper bits stay as the free-bit readback above
			end
		endcase
		if (i_gb_strobed)
		begin
			// group B layout is the same in strobed and bidirectional A modes
			o_word[ppc_pkg::PC_HS_B]   = i_en_b;
			o_word[ppc_pkg::PC_BF_B]   = i_pb_in ? i_ibf_b : i_obf_b;
			o_word[ppc_pkg::PC_INTR_B] = i_irq_b;
		end
	end
endmodule

// File: verif/ppc_host_model.sv
// host model: byte accesses on the port control register bus
`timescale 1ns/1ns
module ppc_host_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rd_valid,
	output logic            o_cs,
	output logic            o_sel_hi,
	output logic            o_sel_lo,
	output logic            o_wr,
	output logic            o_rd,
	output logic [7:0]      o_wdata
);
	initial
	begin
		o_cs = 1'b0;
		{o_sel_hi, o_sel_lo} = 2'h0;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 8'h00;
	end

	// --------------------------------------------------------------
	// bus cycles
	// --------------------------------------------------------------
	// strobes are one-cycle pulses; released lines show inverted values so stale data never matches
	task automatic access(input logic [1:0] sel, input logic cs, input logic wr,
		input logic [7:0] data);
		@(negedge i_clk);
		o_cs = cs;
		{o_sel_hi, o_sel_lo} = sel;
		o_wr = wr;
		o_rd = ~wr;
		o_wdata = data;
		@(negedge i_clk);
		o_cs = 1'b0;
		{o_sel_hi, o_sel_lo} = ~sel;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = ~data;
	endtask

	task automatic write_reg(input logic [1:0] sel, input logic [7:0] data);
		access(sel, 1'b1, 1'b1, data);
	endtask

	task automatic write_off(input logic [1:0] sel, input logic [7:0] data);
		access(sel, 1'b0, 1'b1, data);
	endtask

	task automatic read_reg(input logic [1:0] sel, output logic [7:0] data, output logic valid);
		access(sel, 1'b1, 1'b0, 8'h00);
		valid = i_rd_valid;
		data = i_rdata;
	endtask

	// bench issues a mode word before any other access after reset
	task automatic mode(input logic [7:0] word);
		write_reg(ppc_pkg::SEL_CMD, word | 8'h80);
	endtask

	// free Port C outputs are changed only through set/reset words
	task automatic set_bit(input logic [2:0] idx, input logic lvl);
		write_reg(ppc_pkg::SEL_CMD, {4'h0, idx, lvl});
	endtask
endmodule

// File: verif/ppc_port_ctrl_bench.sv
// self-checking bench for the parallel port control block
`timescale 1ns/1ns
module ppc_port_ctrl_bench;
	logic       i_clk;
	logic       i_rst;
	logic       cs;
	logic       sel_hi;
	logic       sel_lo;
	logic       wr;
	logic       rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rd_valid;
	logic [7:0] pa;
	logic [7:0] pb;
	logic [7:0] pc_in;
	logic [7:0] opc;
	logic [7:0] opa;
	logic [7:0] opb;
	logic [7:0] pc_oe_n;
	logic       pa_oe_n;
	logic       pb_oe_n;
	int         miscompares;
	int         samples_checked;
	logic [7:0] cmds [4] = '{8'h0d, 8'h09, 8'h0c, 8'h08};
	// an output enable with the buffer empty raises the request a cycle later
	logic [7:0] exps [4] = '{8'h48, 8'h58, 8'h10, 8'h00};

	ppc_port_ctrl i_ppc_port_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_cs(cs),
		.i_port_sel_hi(sel_hi), .i_port_sel_lo(sel_lo), .i_wr(wr), .i_rd(rd),
		.i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rd_valid), .i_pa(pa), .o_pa(opa),
		.o_pa_oe_n(pa_oe_n), .i_pb(pb), .o_pb(opb), .o_pb_oe_n(pb_oe_n), .i_pc(pc_in),
		.o_pc(opc), .o_pc_oe_n(pc_oe_n));

	ppc_host_model i_ppc_host_model (.i_clk(i_clk), .i_rdata(rdata), .i_rd_valid(rd_valid),
		.o_cs(cs), .o_sel_hi(sel_hi), .o_sel_lo(sel_lo), .o_wr(wr), .o_rd(rd),
		.o_wdata(wdata));

	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic test_done();
		if (miscompares == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	task automatic rd_chk(input logic [1:0] sel, input logic [7:0] exp, input string what);
		logic [7:0] d;
		logic       v;
		i_ppc_host_model.read_reg(sel, d, v);
		check({7'h0, v}, 8'h01, "read strobe answer");
		check(d, exp, what);
	endtask

	// handshake strobes are low active; held low for one cycle
	task automatic strobe_pc(input logic [7:0] mask);
		@(negedge i_clk);
		pc_in = ~mask;
		@(negedge i_clk);
		pc_in = 8'hff;
		idle(2);
	endtask

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		check(pc_oe_n, 8'hff, "port c released");
		check({6'h0, pa_oe_n, pb_oe_n}, 8'h03, "ports a b released");
		check(opc, 8'h00, "port c drive");
	endtask

	task automatic t_basic();
		i_ppc_host_model.mode(8'h9b);
		pa = 8'h5a;
		rd_chk(ppc_pkg::SEL_PORT_A, 8'h5a, "live input a");
		pa = 8'ha5;
		rd_chk(ppc_pkg::SEL_PORT_A, 8'ha5, "live input a changed");
		pb = 8'h3e;
		rd_chk(ppc_pkg::SEL_PORT_B, 8'h3e, "live input b");
		rd_chk(ppc_pkg::SEL_CMD, 8'h00, "command read");
		i_ppc_host_model.mode(8'h80);
		idle(1);
		check({pc_oe_n[7:1], pa_oe_n | pb_oe_n | pc_oe_n[0]}, 8'h00, "all driven");
		i_ppc_host_model.write_reg(ppc_pkg::SEL_PORT_A, 8'h3c);
		pa = 8'hc3;
		rd_chk(ppc_pkg::SEL_PORT_A, 8'h3c, "latched output a");
		i_ppc_host_model.write_reg(ppc_pkg::SEL_PORT_B, 8'h96);
		rd_chk(ppc_pkg::SEL_PORT_B, 8'h96, "latched output b");
		check(opa, 8'h3c, "port a drive");
		check(opb, 8'h96, "port b drive");
		for (int i = 0; i < 8; i++)
		begin
			i_ppc_host_model.set_bit(3'(i), 1'b1);
			idle(1);
			check(opc, 8'h01 << i, "bit set");
			rd_chk(ppc_pkg::SEL_PORT_C, 8'h01 << i, "port c latch");
			i_ppc_host_model.set_bit(3'(i), 1'b0);
			idle(1);
			check(opc, 8'h00, "bit reset");
		end
		i_ppc_host_model.write_off(ppc_pkg::SEL_CMD, 8'h0f);
		idle(1);
		check(opc, 8'h00, "unselected write");
	endtask

	task automatic t_example();
		i_ppc_host_model.mode(ppc_pkg::EXAMPLE_MODE_WORD);
		idle(1);
		check({1'b0, pc_oe_n[7:3], pa_oe_n, pb_oe_n}, 8'h06, "example directions");
	endtask

	task automatic t_strobed();
		i_ppc_host_model.mode(8'hb1);
		i_ppc_host_model.set_bit(3'h7, 1'b1);
		i_ppc_host_model.set_bit(3'h4, 1'b1);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'h97, "strobed status");
		pa = 8'h66;
		strobe_pc(8'h10);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'hbf, "strobed full");
		check(opc, 8'hb8, "strobed pins");
		i_ppc_host_model.set_bit(3'h5, 1'b0);
		i_ppc_host_model.set_bit(3'h3, 1'b0);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'hbf, "flags kept");
		rd_chk(ppc_pkg::SEL_PORT_A, 8'h66, "strobed data");
		idle(2);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'h97, "full cleared");
	endtask

	// strobed output A: the full pin is low while the byte waits for its ack
	task automatic t_strobed_out();
		i_ppc_host_model.mode(8'ha0);
		i_ppc_host_model.set_bit(3'h6, 1'b1);
		i_ppc_host_model.write_reg(ppc_pkg::SEL_PORT_A, 8'h5c);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'hc0, "strobed out full");
		check(opc, 8'h40, "out full pin low");
		check(opa, 8'h5c, "strobed out data");
		check({7'h0, pa_oe_n}, 8'h00, "strobed out driven");
		strobe_pc(8'h40);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'h48, "ack empties buffer");
		check(opc, 8'hc8, "ack pins");
	endtask

	task automatic t_bidir();
		i_ppc_host_model.mode(8'hc6);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'h00, "bidir cleared");
		for (int i = 0; i < 4; i++)
		begin
			i_ppc_host_model.write_reg(ppc_pkg::SEL_CMD, cmds[i]);
			rd_chk(ppc_pkg::SEL_PORT_C, exps[i], "bidir enable");
		end
		i_ppc_host_model.set_bit(3'h2, 1'b1);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'h04, "enable b");
		i_ppc_host_model.write_reg(ppc_pkg::SEL_PORT_C, 8'h14);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'h14, "direct enables");
		pa = 8'h3c;
		pb = 8'h77;
		strobe_pc(8'h14);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'h3f, "bidir full");
		i_ppc_host_model.write_reg(ppc_pkg::SEL_PORT_C, 8'h00);
		idle(2);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'h22, "flags kept on write");
		rd_chk(ppc_pkg::SEL_PORT_A, 8'h3c, "bidir data a");
		rd_chk(ppc_pkg::SEL_PORT_B, 8'h77, "strobed data b");
		idle(2);
		rd_chk(ppc_pkg::SEL_PORT_C, 8'h00, "reads cleared");
	endtask

	// --------------------------------------------------------------
	// main sequence and watchdog
	// --------------------------------------------------------------
	initial
	begin
		miscompares = 0;
		samples_checked = 0;
		i_rst = 1'b1;
		pa = 8'h00;
		pb = 8'h00;
		pc_in = 8'hff;
		repeat (6) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		t_reset();
		t_basic();
		t_example();
		t_strobed();
		t_strobed_out();
		t_bidir();
		test_done();
	end

	// whole run is well under two thousand cycles
	initial
	begin
		#40000;
		miscompares++;
		test_done();
	end
endmodule
